// ---- fprc_host.sv ----
`timescale 1ns/1ps
module fprc_host
  import fprc_pkg::*;
#(
  parameter int RESET_LOW_CYCLES = RESET_LOW_CYC
) (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire logic                power_good,
  input  wire logic                req_valid,
  input  wire fprc_req_t           req,
  output logic                     req_ready,
  output logic                     rsp_valid,
  output logic [DATA_W-1:0]        rsp_data,
  output logic                     supply_error_flag,
  output logic                     array_mode,
  output fprc_ctl_t                ctl,
  output logic [ADDR_W-1:0]        flash_addr,
  output logic [DATA_W-1:0]        flash_dq_out,
  output logic                     flash_dq_oe,
  input  wire logic [DATA_W-1:0]   flash_dq_in
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [6:0] {
    ST_DOWN  = 7'b0000001,
    ST_REC   = 7'b0000010,
    ST_IDLE  = 7'b0000100,
    ST_READ  = 7'b0001000,
    ST_WRITE = 7'b0010000,
    ST_HOLD  = 7'b0100000,
    ST_SLEEP = 7'b1000000
  } fprc_state_t;

  fprc_state_t        state_r;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   rec_r;
  logic               pg_s1_r;
  logic               pg_s2_r;
  logic [DATA_W-1:0]  dq_s1_r;
  logic [DATA_W-1:0]  dq_s2_r;
  logic               write_op;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n);
  endfunction

  assign write_op = (req.op == FPRC_OP_WRITE);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pg_s1_r <= 1'b0;
      pg_s2_r <= 1'b0;
      dq_s1_r <= '0;
      dq_s2_r <= '0;
    end else begin
      pg_s1_r <= power_good;
      pg_s2_r <= pg_s1_r;
      dq_s1_r <= flash_dq_in;
      dq_s2_r <= dq_s1_r;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // Reset pin follows power good so supply ramps are masked
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r   <= ST_DOWN;
      cnt_r     <= '0;
      rec_r     <= '0;
      ctl       <= '{cs_n: RST_CS_N, oe_n: RST_OE_N, we_n: RST_WE_N,
                     powerdown_reset_n: RST_PD_N};
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
      flash_addr   <= '0;
      flash_dq_out <= '0;
      flash_dq_oe  <= 1'b0;
      array_mode   <= 1'b1;
      supply_error_flag <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      if (cnt_r != '0) cnt_r <= cnt_r - 1'b1;
      if (rec_r != '0) rec_r <= rec_r - 1'b1;
      if (!pg_s2_r && state_r != ST_DOWN) begin
        // Power loss: drop everything, device status is lost too
        state_r <= ST_DOWN;
        ctl     <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, powerdown_reset_n: 1'b0};
        flash_dq_oe <= 1'b0;
        req_ready   <= 1'b0;
        cnt_r       <= cyc(RESET_LOW_CYCLES);
        array_mode  <= 1'b1;
        supply_error_flag <= 1'b0;
      end else begin
        unique case (state_r)
          ST_DOWN: begin
            if (pg_s2_r && cnt_r == '0) begin
              ctl.powerdown_reset_n <= 1'b1;
              rec_r   <= cyc(REC_WRITE_CYC > REC_READ_CYC ? REC_WRITE_CYC : REC_READ_CYC);
              state_r <= ST_REC;
            end
          end
          ST_REC: begin
            if (rec_r == '0) begin
              req_ready <= 1'b1;
              state_r   <= ST_IDLE;
            end
          end
          ST_IDLE: begin
            if (req_valid) begin
              req_ready  <= 1'b0;
              flash_addr <= req.addr;
              unique case (req.op)
                FPRC_OP_SLEEP: begin
                  ctl.powerdown_reset_n <= 1'b0;
                  cnt_r   <= cyc(RESET_LOW_CYCLES);
                  array_mode <= 1'b1;
                  supply_error_flag <= 1'b0;
                  state_r <= ST_SLEEP;
                end
                FPRC_OP_WAKE: begin
                  req_ready <= 1'b1;
                end
                default: begin
                  // Both strobes low are needed for a command write
                  ctl.cs_n    <= 1'b0;
                  ctl.oe_n    <= write_op;
                  ctl.we_n    <= !write_op;
                  flash_dq_out <= req.wdata;
                  flash_dq_oe  <= write_op;
                  cnt_r   <= cyc(write_op ? STROBE_CYC : ACCESS_CYC + 2);
                  state_r <= write_op ? ST_WRITE : ST_READ;
                  if (write_op) begin
                    array_mode <= (req.wdata[7:0] == CMD_READ_ARRAY);
                  end
                end
              endcase
            end
          end
          ST_READ: begin
            // Two extra cycles cover the data synchroniser
            if (cnt_r == '0) begin
              rsp_data  <= dq_s2_r;
              rsp_valid <= 1'b1;
              if (!array_mode) supply_error_flag <= dq_s2_r[SUPPLY_ERR_BIT];
              ctl.cs_n  <= 1'b1;
              ctl.oe_n  <= 1'b1;
              cnt_r     <= cyc(1);
              state_r   <= ST_HOLD;
            end
          end
          ST_WRITE: begin
            if (cnt_r == '0) begin
              ctl.we_n  <= 1'b1;
              ctl.cs_n  <= 1'b1;
              cnt_r     <= cyc(1);
              state_r   <= ST_HOLD;
            end
          end
          ST_HOLD: begin
            if (cnt_r == '0) begin
              flash_dq_oe <= 1'b0;
              req_ready   <= 1'b1;
              state_r     <= ST_IDLE;
            end
          end
          ST_SLEEP: begin
            if (req_valid && req.op == FPRC_OP_WAKE && cnt_r == '0) begin
              ctl.powerdown_reset_n <= 1'b1;
              rec_r   <= cyc(REC_WRITE_CYC > REC_READ_CYC ? REC_WRITE_CYC : REC_READ_CYC);
              state_r <= ST_REC;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_write_strobes: assert property (@(posedge clk) disable iff (!nrst)
    !ctl.we_n |-> !ctl.cs_n && ctl.powerdown_reset_n)
    else $error("write strobe without chip select");
  a_sleep_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !ctl.powerdown_reset_n |-> ctl.cs_n && ctl.we_n && ctl.oe_n && !flash_dq_oe)
    else $error("bus active in power-down");
  a_rec_wait: assert property (@(posedge clk) disable iff (!nrst)
    $rose(ctl.powerdown_reset_n) |-> ctl.cs_n [*2])
    else $error("access too soon after reset release");
  a_pg_down: assert property (@(posedge clk) disable iff (!nrst)
    !pg_s2_r |=> !ctl.powerdown_reset_n)
    else $error("reset pin high without power good");
  a_array_cmd: assert property (@(posedge clk) disable iff (!nrst)
    (state_r == ST_IDLE && req_valid && write_op && req.wdata[7:0] == CMD_READ_ARRAY && pg_s2_r)
      |=> array_mode)
    else $error("read-array not tracked");
  a_sleep_clear: assert property (@(posedge clk) disable iff (!nrst)
    $fell(ctl.powerdown_reset_n) |-> !supply_error_flag && array_mode)
    else $error("status not cleared on power-down");
  a_strobe_len: assert property (@(posedge clk) disable iff (!nrst)
    $fell(ctl.we_n) |-> !ctl.we_n [*2])
    else $error("write strobe too short");

endmodule

// ---- fprc_pkg.sv ----
package fprc_pkg;

  // ----------------------------------------------------------------
  // Bus widths and command codes
  // ----------------------------------------------------------------
  localparam int          ADDR_W          = 22;
  localparam int          DATA_W          = 16;
  localparam logic [7:0]  CMD_READ_ARRAY  = 8'hff;
  localparam logic [7:0]  CMD_READ_STATUS = 8'h70;
  localparam logic [7:0]  CMD_CLEAR_STAT  = 8'h50;
  localparam int          SUPPLY_ERR_BIT  = 3;
  localparam int          READY_BIT       = 7;

  // ----------------------------------------------------------------
  // Timing at 10 MHz (100 ns period)
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS      = 100;
  localparam int T_RESET_LOW_NS     = 150;
  localparam int T_REC_READ_NS      = 150;
  localparam int T_REC_WRITE_NS     = 150;
  localparam int T_STROBE_NS        = 100;
  localparam int T_ACCESS_NS        = 100;
  localparam int RESET_LOW_CYC  = (T_RESET_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_READ_CYC   = (T_REC_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REC_WRITE_CYC  = (T_REC_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC     = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACCESS_CYC     = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W          = 8;

  // ----------------------------------------------------------------
  // Reset values of the flash pins
  // ----------------------------------------------------------------
  localparam logic RST_CS_N = 1'b1;
  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_WE_N = 1'b1;
  localparam logic RST_PD_N = 1'b0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPRC_OP_READ  = 2'h0,
    FPRC_OP_WRITE = 2'h1,
    FPRC_OP_SLEEP = 2'h2,
    FPRC_OP_WAKE  = 2'h3
  } fprc_op_t;

  typedef struct packed {
    fprc_op_t            op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata;
  } fprc_req_t;

  typedef struct packed {
    logic                cs_n;
    logic                oe_n;
    logic                we_n;
    logic                powerdown_reset_n;
  } fprc_ctl_t;

endpackage

// ---- fprc_flash_model.sv ----
`timescale 1ns/1ps
module fprc_flash_model
  import fprc_pkg::*;
(
  input  wire logic              clk,
  input  wire fprc_ctl_t         ctl,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] dq_host,
  input  wire logic              vpp_low,
  output logic [DATA_W-1:0]      dq,
  output int                     viol
);
  logic              arr_r;
  logic              pend_r;
  logic              wr_r;
  logic [7:0]        stat_r;
  logic [DATA_W-1:0] last_r;
  logic [DATA_W-1:0] wd_r;
  int                rec_r;
  wire drive = ctl.powerdown_reset_n && !ctl.cs_n && !ctl.oe_n;
  // Undriven bus flips every cycle so a stale value never looks valid
  assign dq = drive ? (arr_r ? (addr[15:0] ^ 16'h5a5a) : {8'h00, stat_r}) : ~last_r;
  initial begin
    viol = 0;
    last_r = 16'h0000;
  end
  always @(posedge clk) begin
    // Keep toggling while released, even if the select lines start out unknown
    last_r <= (drive === 1'b1) ? dq : ~last_r;
    wr_r <= ctl.powerdown_reset_n && !ctl.cs_n && !ctl.we_n;
    wd_r <= dq_host;
    if (!ctl.powerdown_reset_n) begin
      arr_r <= 1'b1;
      pend_r <= 1'b0;
      stat_r <= 8'h80;
      rec_r <= 0;
    end else begin
      if (rec_r < 8) rec_r <= rec_r + 1;
      if (!ctl.cs_n && rec_r < REC_READ_CYC) viol <= viol + 1;
      if (wr_r && (ctl.cs_n || ctl.we_n)) begin
        if (pend_r) begin
          pend_r <= 1'b0;
          arr_r <= 1'b0;
          if (vpp_low) stat_r[3] <= 1'b1;
        end else begin
          case (wd_r[7:0])
            8'hff: arr_r <= 1'b1;
            8'h70: arr_r <= 1'b0;
            8'h50: stat_r[3] <= 1'b0;
            8'h40: begin
              pend_r <= 1'b1;
              arr_r <= 1'b0;
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
  import fprc_pkg::*;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              power_good = 1'b1;
  logic              req_valid = 1'b0;
  fprc_req_t         req = '0;
  logic              vpp_low = 1'b0;
  logic              req_ready, rsp_valid, sup_err, arr_mode, dq_oe;
  logic [DATA_W-1:0] rsp_data, dq_out, dq_in, got;
  logic [ADDR_W-1:0] faddr, a;
  fprc_ctl_t         ctl;
  int                miscompares = 0;
  int                tests_run = 0;
  int                viol;

  always #50 clk = ~clk;

  fprc_host #(.RESET_LOW_CYCLES(2)) uut (
    .clk(clk), .nrst(nrst), .power_good(power_good), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .supply_error_flag(sup_err), .array_mode(arr_mode), .ctl(ctl), .flash_addr(faddr),
    .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in));
  fprc_flash_model flash (
    .clk(clk), .ctl(ctl), .addr(faddr), .dq_host(dq_out), .vpp_low(vpp_low),
    .dq(dq_in), .viol(viol));

  // ----------------------------------------------------------------
  // Checking and request tasks
  // ----------------------------------------------------------------
  function automatic logic [DATA_W-1:0] exp_arr(logic [ADDR_W-1:0] ad);
    return ad[15:0] ^ 16'h5a5a;
  endfunction

  task automatic check(logic ok, string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("MISMATCH at %0t: %s", $time, msg);
    end
  endtask

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic do_req(fprc_op_t op, logic [ADDR_W-1:0] ad, logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(n < 100, "request never taken");
    req_valid = 1'b1;
    req = '{op: op, addr: ad, wdata: d};
    @(negedge clk);
    req_valid = 1'b0;
  endtask

  task automatic do_read(logic [ADDR_W-1:0] ad);
    int n;
    do_req(FPRC_OP_READ, ad, 16'h0000);
    n = 0;
    while (rsp_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    check(n < 20, "read answer missing");
    got = rsp_data;
  endtask

  // Wake is taken while asleep, so ready stays low: hold it until ready returns
  task automatic do_wake();
    int n;
    n = 0;
    @(negedge clk);
    req_valid = 1'b1;
    req = '{op: FPRC_OP_WAKE, addr: '0, wdata: '0};
    @(negedge clk);
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    check(n < 100, "wake never taken");
    req_valid = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'ha2092864));
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    for (int i = 0; i < 6; i++) begin
      a = ADDR_W'($urandom);
      do_read(a);
      check(got === exp_arr(a) && arr_mode === 1'b1, "array read after reset");
    end
    do_req(FPRC_OP_WRITE, 22'h000000, {8'h00, CMD_READ_STATUS});
    do_read(22'h000000);
    check(got === 16'h0080 && arr_mode === 1'b0 && sup_err === 1'b0, "status");
    vpp_low = 1'b1;
    a = ADDR_W'($urandom);
    do_req(FPRC_OP_WRITE, a, 16'h0040);
    // Program data must not end in ff, or the host would take it for read-array
    do_req(FPRC_OP_WRITE, a, 16'($urandom) & 16'hff7f);
    do_read(a);
    check(got === 16'h0088 && sup_err === 1'b1, "lockout error not seen");
    do_req(FPRC_OP_WRITE, a, {8'h00, CMD_READ_ARRAY});
    do_read(a);
    check(got === exp_arr(a) && arr_mode === 1'b1, "read array command");
    do_req(FPRC_OP_WRITE, 22'h000000, {8'h00, CMD_READ_STATUS});
    do_req(FPRC_OP_SLEEP, 22'h000000, 16'h0000);
    repeat (6) @(negedge clk);
    check(ctl.powerdown_reset_n === 1'b0 && dq_oe === 1'b0, "sleep pin");
    do_wake();
    a = ADDR_W'($urandom);
    do_read(a);
    check(got === exp_arr(a) && sup_err === 1'b0, "wake state");
    do_req(FPRC_OP_WAKE, 22'h000000, 16'h0000);
    @(negedge clk);
    check(req_ready === 1'b1 && ctl.powerdown_reset_n === 1'b1, "wake in idle");
    power_good = 1'b0;
    repeat (4) @(negedge clk);
    check(ctl.powerdown_reset_n === 1'b0 && ctl.we_n === 1'b1, "power loss");
    power_good = 1'b1;
    do_read(a);
    check(got === exp_arr(a), "read after power return");
    check(viol == 0, "access inside recovery time");
    finish_test();
  end

  initial begin
    #2000000;
    miscompares++;
    finish_test();
  end
endmodule
